// ==== hw/rmcc_pkg.sv ====
/*
  Package for the run-mode clock configuration block: register offsets,
  field positions, reset values and the carrier types.
  Assumes a 32-bit word register port and a 125 MHz system clock.
*/
package rmcc_pkg;
  localparam logic [11:0] RMCC_OFF_RCC       = 12'h0_060;
  localparam logic [11:0] RMCC_OFF_STATUS    = 12'h0_064;
  localparam logic [11:0] RMCC_OFF_SLEEP     = 12'h0_068;
  localparam int          RMCC_POS_ACG       = 27;
  localparam int          RMCC_POS_SYSTEM_DIVISOR    = 23;
  localparam int          RMCC_POS_USESYS    = 22;
  localparam int          RMCC_POS_USEPWM    = 20;
  localparam int          RMCC_POS_PWM_PREDIVISOR    = 17;
  localparam int          RMCC_POS_BYPASS    = 11;
  localparam logic        RMCC_RST_ACG       = 1'b0;
  localparam logic [3:0]  RMCC_RST_SYSTEM_DIVISOR    = 4'hF;
  localparam logic        RMCC_RST_USESYS    = 1'b0;
  localparam logic        RMCC_RST_USEPWM    = 1'b0;
  localparam logic [2:0]  RMCC_RST_PWM_PREDIVISOR    = 3'h7;
  localparam logic        RMCC_RST_BYPASS    = 1'b1;
  localparam logic [3:0]  RMCC_PLL_MINDIV    = 4'h7;
  localparam logic [2:0]  RMCC_PWM_MAXCODE   = 3'h5;

  typedef enum logic [1:0] {RMCC_RUN, RMCC_SLEEP, RMCC_DEEP} rmcc_mode_t;
  typedef enum logic [1:0] {RMCC_GATE_RUN, RMCC_GATE_SLEEP, RMCC_GATE_DEEP} rmcc_gsel_t;

  typedef struct packed {
    logic       auto_sleep_gating;
    logic [3:0] system_divisor;
    logic       usesys;
    logic       usepwm;
    logic [2:0] pwm_predivisor;
    logic       bypass;
  } rmcc_cfg_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } rmcc_bus_t;
endpackage

// ==== hw/rmcc_top.sv ====
/*
  Run-mode clock configuration: register, gating set select, system
  divider and PWM predivider producing single-cycle clock enables.
  Assumes the bus master and the power mode input share this clock.
*/
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE_01] Auto gating set: sleep uses sleep gate set, deep sleep uses deep set
// [RULE_02] Auto gating clear: run gate set stays in charge during both sleeps
// [RULE_03] Run mode always uses run gate set
// [RULE_04] Divisor field 26:23 resets to F, divides by value plus one
// [RULE_05] With PLL, divisors below minimum capability are raised to it
// [RULE_06] Bit 22 applies the divider; forced when the source needs it
// [RULE_07] Bit 20 makes predivider output the PWM clock, else not
// [RULE_08] Bypass clear uses PLL divided; bypass set uses oscillator
// [RULE_09] PWM predivider is power of two, /2 to /64, edges aligned
// [RULE_10] Reserved bits read zero; config changes apply glitch free
module rmcc_top #(
  parameter logic [3:0] MIN_DIV = rmcc_pkg::RMCC_PLL_MINDIV
) (
  input  wire logic                 clock,
  input  wire logic                 nrst,
  input  wire rmcc_pkg::rmcc_bus_t  bus,
  input  wire rmcc_pkg::rmcc_mode_t power_mode,
  input  wire logic                 src_needs_div,
  output logic [31:0]               rdata_r,
  output rmcc_pkg::rmcc_gsel_t      gate_sel_r,
  output logic                      sys_clk_en_r,
  output logic                      pwm_clk_en_r,
  output logic                      sys_from_pll_r,
  output logic [3:0]                eff_div_r
);
  import rmcc_pkg::*;

  rmcc_cfg_t  cfg_r, cfg_nxt;
  rmcc_gsel_t gsel_nxt;
  logic [31:0] rdata_nxt;
  logic [3:0]  sys_cnt_r, sys_cnt_nxt, div_nxt;
  logic [5:0]  pwm_cnt_r, pwm_cnt_nxt;
  logic        sys_en_nxt, pwm_en_nxt, pll_nxt, div_on;
  logic [5:0]  pwm_mask;

  // Exact match only, so no alias can let a stray write reach the clock tree
  function automatic logic reg_hit(input logic [11:0] addr, input logic [11:0] off);
    reg_hit = (addr == off);
  endfunction

  function automatic logic [5:0] pwm_mask_of(input logic [2:0] code);
    logic [2:0] c;
    c = (code > RMCC_PWM_MAXCODE) ? RMCC_PWM_MAXCODE : code; // RULE_09
    pwm_mask_of = 6'h3F >> (RMCC_PWM_MAXCODE - c);
  endfunction

  always_comb begin
    cfg_nxt = cfg_r;
    rdata_nxt = 32'h0000_0000; // RULE_10
    if (bus.wr && reg_hit(bus.addr, RMCC_OFF_RCC)) begin
      cfg_nxt.auto_sleep_gating    = bus.wdata[RMCC_POS_ACG];
      cfg_nxt.system_divisor = bus.wdata[RMCC_POS_SYSTEM_DIVISOR +: 4]; // RULE_04
      cfg_nxt.usesys = bus.wdata[RMCC_POS_USESYS]; // RULE_06
      cfg_nxt.usepwm = bus.wdata[RMCC_POS_USEPWM]; // RULE_07
      cfg_nxt.pwm_predivisor = bus.wdata[RMCC_POS_PWM_PREDIVISOR +: 3];
      cfg_nxt.bypass = bus.wdata[RMCC_POS_BYPASS];
    end
    if (bus.rd) begin
      if (reg_hit(bus.addr, RMCC_OFF_RCC)) begin
        rdata_nxt[RMCC_POS_ACG]         = cfg_r.auto_sleep_gating;
        rdata_nxt[RMCC_POS_SYSTEM_DIVISOR +: 4] = cfg_r.system_divisor;
        rdata_nxt[RMCC_POS_USESYS]      = cfg_r.usesys;
        rdata_nxt[RMCC_POS_USEPWM]      = cfg_r.usepwm;
        rdata_nxt[RMCC_POS_PWM_PREDIVISOR +: 3] = cfg_r.pwm_predivisor;
        rdata_nxt[RMCC_POS_BYPASS]      = cfg_r.bypass;
      end else if (reg_hit(bus.addr, RMCC_OFF_STATUS)) begin
        rdata_nxt[3:0] = eff_div_r;
        rdata_nxt[5:4] = gate_sel_r;
        rdata_nxt[6]   = sys_from_pll_r;
      end
    end
  end

  always_comb begin
    gsel_nxt = RMCC_GATE_RUN; // RULE_03
    if (cfg_r.auto_sleep_gating) begin
      case (power_mode)
        RMCC_SLEEP: gsel_nxt = RMCC_GATE_SLEEP; // RULE_01
        RMCC_DEEP:  gsel_nxt = RMCC_GATE_DEEP; // RULE_01
        default:    gsel_nxt = RMCC_GATE_RUN;
      endcase
    end
    // Without auto gating the run set governs every mode
    if (!cfg_r.auto_sleep_gating) gsel_nxt = RMCC_GATE_RUN; // RULE_02
  end

  // Divider reload only at a terminal count so a change never cuts a period short
  always_comb begin
    pll_nxt = !cfg_r.bypass; // RULE_08
    div_on  = cfg_r.usesys || src_needs_div || pll_nxt; // RULE_06
    div_nxt = cfg_r.system_divisor;
    if (pll_nxt && cfg_r.system_divisor < MIN_DIV) div_nxt = MIN_DIV; // RULE_05
    if (!div_on) div_nxt = 4'h0;
    sys_cnt_nxt = sys_cnt_r - 4'h1;
    sys_en_nxt  = 1'b0;
    if (sys_cnt_r == 4'h0) begin
      sys_cnt_nxt = div_nxt; // RULE_10
      sys_en_nxt  = 1'b1; // RULE_04
    end
  end

  always_comb begin
    pwm_mask    = pwm_mask_of(cfg_r.pwm_predivisor);
    pwm_cnt_nxt = pwm_cnt_r;
    // Count divided system pulses so every PWM edge sits on a system clock edge
    if (sys_en_nxt) pwm_cnt_nxt = (pwm_cnt_r + 6'h01) & pwm_mask; // RULE_09
    pwm_en_nxt  = cfg_r.usepwm ? (sys_en_nxt && pwm_cnt_r == pwm_mask) : sys_en_nxt; // RULE_07
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      cfg_r   <= '{RMCC_RST_ACG, RMCC_RST_SYSTEM_DIVISOR, RMCC_RST_USESYS,
                   RMCC_RST_USEPWM, RMCC_RST_PWM_PREDIVISOR, RMCC_RST_BYPASS};
      rdata_r <= 32'h0000_0000;
    end else begin
      cfg_r   <= cfg_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      gate_sel_r <= RMCC_GATE_RUN;
    end else begin
      gate_sel_r <= gsel_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sys_cnt_r      <= 4'h0;
      sys_clk_en_r   <= 1'b0;
      sys_from_pll_r <= 1'b0;
      eff_div_r      <= 4'h0;
    end else begin
      sys_cnt_r      <= sys_cnt_nxt;
      sys_clk_en_r   <= sys_en_nxt;
      sys_from_pll_r <= pll_nxt;
      eff_div_r      <= div_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pwm_cnt_r    <= 6'h00;
      pwm_clk_en_r <= 1'b0;
    end else begin
      pwm_cnt_r    <= pwm_cnt_nxt;
      pwm_clk_en_r <= pwm_en_nxt;
    end
  end

  // Assertion helpers: cycles since the last pulse of each divided clock, saturating
  logic [4:0]  sys_gap_r, sys_gap_nxt;
  logic [10:0] pwm_gap_r, pwm_gap_nxt;

  always_comb begin
    sys_gap_nxt = (sys_gap_r == 5'h1F) ? sys_gap_r : sys_gap_r + 5'h01;
    pwm_gap_nxt = (pwm_gap_r == 11'h7FF) ? pwm_gap_r : pwm_gap_r + 11'h001;
    if (sys_clk_en_r) sys_gap_nxt = 5'h00;
    if (pwm_clk_en_r) pwm_gap_nxt = 11'h000;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      sys_gap_r <= 5'h00;
      pwm_gap_r <= 11'h000;
    end else begin
      sys_gap_r <= sys_gap_nxt;
      pwm_gap_r <= pwm_gap_nxt;
    end
  end

  property p_sleep_sel;
    @(posedge clock) disable iff (!nrst)
      (cfg_r.auto_sleep_gating && power_mode == RMCC_SLEEP) |=> gate_sel_r == RMCC_GATE_SLEEP;
  endproperty
  a_sleep_sel: assert property (p_sleep_sel) else $error("sleep set not chosen"); // RULE_01

  property p_no_acg;
    @(posedge clock) disable iff (!nrst)
      !cfg_r.auto_sleep_gating |=> gate_sel_r == RMCC_GATE_RUN;
  endproperty
  a_no_acg: assert property (p_no_acg) else $error("run set not kept"); // RULE_02

  property p_run_sel;
    @(posedge clock) disable iff (!nrst)
      power_mode == RMCC_RUN |=> gate_sel_r == RMCC_GATE_RUN;
  endproperty
  a_run_sel: assert property (p_run_sel) else $error("run mode not on run set"); // RULE_03

  property p_min_div;
    @(posedge clock) disable iff (!nrst)
      !cfg_r.bypass |=> eff_div_r >= MIN_DIV;
  endproperty
  a_min_div: assert property (p_min_div) else $error("divisor below minimum"); // RULE_05

  property p_sys_period;
    @(posedge clock) disable iff (!nrst)
      (sys_clk_en_r && eff_div_r == 4'h1 && $stable(eff_div_r)) |=> !sys_clk_en_r ##1 sys_clk_en_r;
  endproperty
  a_sys_period: assert property (p_sys_period) else $error("divide by two wrong"); // RULE_04

  property p_pll_src;
    @(posedge clock) disable iff (!nrst)
      1'b1 |=> sys_from_pll_r == !$past(cfg_r.bypass);
  endproperty
  a_pll_src: assert property (p_pll_src) else $error("source select wrong"); // RULE_08

  property p_pwm_div2;
    @(posedge clock) disable iff (!nrst)
      (cfg_r.usepwm && cfg_r.pwm_predivisor == 3'h0 && pwm_clk_en_r && eff_div_r == 4'h0
        && $stable(cfg_r.usepwm)) ##1 ($stable(cfg_r) && $stable(eff_div_r))
        |-> !pwm_clk_en_r ##1 pwm_clk_en_r;
  endproperty
  a_pwm_div2: assert property (p_pwm_div2) else $error("pwm divide by two wrong"); // RULE_09

  property p_pwm_off;
    @(posedge clock) disable iff (!nrst)
      !cfg_r.usepwm |=> pwm_clk_en_r == sys_clk_en_r;
  endproperty
  a_pwm_off: assert property (p_pwm_off) else $error("pwm uses divider while off"); // RULE_07

  property p_rsvd;
    @(posedge clock) disable iff (!nrst)
      1'b1 |-> rdata_r[31:28] == 4'h0 && rdata_r[21] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero"); // RULE_10

  property p_deep_sel;
    @(posedge clock) disable iff (!nrst)
      (cfg_r.auto_sleep_gating && power_mode == RMCC_DEEP) |=> gate_sel_r == RMCC_GATE_DEEP;
  endproperty
  a_deep_sel: assert property (p_deep_sel) else $error("deep set not chosen"); // RULE_01

  // Reset gating in the antecedent: the first edge after release still shows reset values
  property p_div_force;
    @(posedge clock) disable iff (!nrst)
      (nrst && cfg_r.bypass && (cfg_r.usesys || src_needs_div)) |=> eff_div_r == $past(cfg_r.system_divisor);
  endproperty
  a_div_force: assert property (p_div_force) else $error("divider not applied"); // RULE_06

  property p_div_off;
    @(posedge clock) disable iff (!nrst)
      (nrst && cfg_r.bypass && !cfg_r.usesys && !src_needs_div) |=> eff_div_r == 4'h0;
  endproperty
  a_div_off: assert property (p_div_off) else $error("divider used while off"); // RULE_06

  property p_pll_floor;
    @(posedge clock) disable iff (!nrst)
      (nrst && !cfg_r.bypass && cfg_r.system_divisor >= MIN_DIV) |=> eff_div_r == $past(cfg_r.system_divisor);
  endproperty
  a_pll_floor: assert property (p_pll_floor) else $error("legal divisor altered"); // RULE_05

  property p_rcc_read;
    @(posedge clock) disable iff (!nrst)
      (bus.rd && reg_hit(bus.addr, RMCC_OFF_RCC))
        |=> rdata_r[RMCC_POS_SYSTEM_DIVISOR +: 4] == $past(cfg_r.system_divisor);
  endproperty
  a_rcc_read: assert property (p_rcc_read) else $error("divisor field read wrong"); // RULE_04

  property p_stat_read;
    @(posedge clock) disable iff (!nrst)
      (bus.rd && reg_hit(bus.addr, RMCC_OFF_STATUS)) |=> rdata_r[3:0] == $past(eff_div_r);
  endproperty
  a_stat_read: assert property (p_stat_read) else $error("status divisor wrong"); // RULE_05

  property p_rd_idle;
    @(posedge clock) disable iff (!nrst)
      !bus.rd |=> rdata_r == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle"); // RULE_10

  property p_rd_unmapped;
    @(posedge clock) disable iff (!nrst)
      (bus.rd && !reg_hit(bus.addr, RMCC_OFF_RCC) && !reg_hit(bus.addr, RMCC_OFF_STATUS))
        |=> rdata_r == 32'h0000_0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read nonzero"); // RULE_10

  property p_pwm_align;
    @(posedge clock) disable iff (!nrst)
      pwm_clk_en_r |-> sys_clk_en_r;
  endproperty
  a_pwm_align: assert property (p_pwm_align) else $error("pwm edge off system edge"); // RULE_09

  // Longest system period is sixteen cycles
  property p_sys_bound;
    @(posedge clock) disable iff (!nrst)
      1'b1 |-> sys_gap_r <= 5'h0F;
  endproperty
  a_sys_bound: assert property (p_sys_bound) else $error("system period too long"); // RULE_04

  // Longest PWM period is sixty-four of the longest system periods
  property p_pwm_bound;
    @(posedge clock) disable iff (!nrst)
      1'b1 |-> pwm_gap_r <= 11'h3FF;
  endproperty
  a_pwm_bound: assert property (p_pwm_bound) else $error("pwm period too long"); // RULE_09

  c_sleep: cover property (@(posedge clock) gate_sel_r == RMCC_GATE_SLEEP);
  c_deep:  cover property (@(posedge clock) gate_sel_r == RMCC_GATE_DEEP);
  c_pll:   cover property (@(posedge clock) sys_from_pll_r && sys_clk_en_r);
  c_pwm:   cover property (@(posedge clock) cfg_r.usepwm && pwm_clk_en_r);
  c_div2:  cover property (@(posedge clock) sys_clk_en_r && eff_div_r == 4'h1);
endmodule
`default_nettype wire

// ==== tb/tb_top.sv ====
/*
  Bench for the run-mode clock configuration block: register reads, gate select,
  divisor and enable spacing. Assumes rmcc_pkg and rmcc_top compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rmcc_pkg::*;
  // Only held fields survive; reserved and lower PLL bits read zero
  localparam logic [31:0] MASK = 32'h0FDE_0800;
  // Per case: {bypass, usesys, src_needs_div, 0}, divisor code, expected applied divisor
  localparam logic [11:0] DT [5] = '{12'h037, 12'h099, 12'hC33, 12'hA11, 12'h850};
  logic        clock = 1'b0;
  logic        nrst = 1'b0;
  rmcc_bus_t   bus = '0;
  rmcc_mode_t  power_mode = RMCC_RUN;
  logic        src_needs_div = 1'b0;
  logic [31:0] rdata_r;
  rmcc_gsel_t  gate_sel_r;
  logic        sys_clk_en_r;
  logic        pwm_clk_en_r;
  logic        sys_from_pll_r;
  logic [3:0]  eff_div_r;
  logic [31:0] exp_q[$];
  logic        pend = 1'b0;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          cyc = 0;
  always #4 clock = ~clock;
  rmcc_top rmcc_top_inst (.clock(clock), .nrst(nrst), .bus(bus), .power_mode(power_mode),
    .src_needs_div(src_needs_div), .rdata_r(rdata_r), .gate_sel_r(gate_sel_r),
    .sys_clk_en_r(sys_clk_en_r), .pwm_clk_en_r(pwm_clk_en_r),
    .sys_from_pll_r(sys_from_pll_r), .eff_div_r(eff_div_r));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Read data stands only in the cycle after the strobe, so compare exactly there
  always @(posedge clock) begin
    pend <= bus.rd;
    cyc <= cyc + 1;
    if (pend) check("read data", rdata_r, exp_q.pop_front());
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  function automatic logic [31:0] cfg(input logic auto_sleep_gating, input logic [3:0] sd, input logic us,
      input logic up, input logic [2:0] pd, input logic bp);
    return {4'h0, auto_sleep_gating, sd, us, 1'b0, up, pd, 5'h00, bp, 11'h000};
  endfunction
  function automatic logic [31:0] stat(input logic [3:0] d, input logic [1:0] g, input logic p);
    return {25'h000_0000, p, g, d};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
  endtask
  // Cycles between two enable pulses; a hang is cut by the cycle ceiling
  task automatic gap(input logic pwm, output int n);
    n = 0;
    do @(posedge clock); while (!(pwm ? pwm_clk_en_r : sys_clk_en_r));
    do begin
      @(posedge clock);
      n++;
    end while (!(pwm ? pwm_clk_en_r : sys_clk_en_r));
  endtask
  initial begin
    int g;
    logic [31:0] v;
    void'($urandom(60));
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    rd(RMCC_OFF_RCC, 32'h078E_0800);
    rd(RMCC_OFF_STATUS, 32'h0000_0000);
    for (int i = 0; i < 8; i++) begin
      v = $urandom();
      wr(RMCC_OFF_RCC, v);
      rd(RMCC_OFF_RCC, v & MASK);
    end
    wr(RMCC_OFF_SLEEP, 32'hFFFF_FFFF);
    rd(RMCC_OFF_SLEEP, 32'h0000_0000);
    rd(RMCC_OFF_RCC, v & MASK);
    for (int a = 0; a < 2; a++)
      for (int m = 0; m < 3; m++) begin
        wr(RMCC_OFF_RCC, cfg(a == 0, 4'h3, 1'b0, 1'b0, 3'h0, 1'b1));
        power_mode <= rmcc_mode_t'(m);
        repeat (20) @(posedge clock);
        check("gate select", 32'(gate_sel_r), 32'(a == 0 ? m : 0));
        rd(RMCC_OFF_STATUS, stat(4'h0, a == 0 ? m[1:0] : 2'h0, 1'b0));
      end
    for (int i = 0; i < 5; i++) begin
      src_needs_div <= DT[i][9];
      wr(RMCC_OFF_RCC, cfg(1'b0, DT[i][7:4], DT[i][10], 1'b0, 3'h0, DT[i][11]));
      repeat (40) @(posedge clock);
      check("applied divisor", 32'(eff_div_r), 32'(DT[i][3:0]));
      check("pll source", 32'(sys_from_pll_r), 32'(!DT[i][11]));
      rd(RMCC_OFF_STATUS, stat(DT[i][3:0], 2'h0, !DT[i][11]));
      gap(1'b0, g);
      check("system enable spacing", 32'(g), 32'(DT[i][3:0]) + 1);
    end
    for (int c = 0; c < 8; c++) begin
      wr(RMCC_OFF_RCC, cfg(1'b0, 4'h1, 1'b0, 1'b1, c[2:0], 1'b1));
      repeat (70) @(posedge clock);
      gap(1'b1, g);
      check("pwm enable spacing", 32'(g), 32'h0000_0002 << (c > 5 ? 5 : c));
    end
    // Without the predivider the PWM enable must follow the divided system enable
    wr(RMCC_OFF_RCC, cfg(1'b0, 4'h3, 1'b1, 1'b0, 3'h0, 1'b1));
    repeat (40) @(posedge clock);
    gap(1'b1, g);
    check("pwm follows system", 32'(g), 32'h0000_0004);
    // Predivider counts divided system pulses: /4 on a /3 system clock
    wr(RMCC_OFF_RCC, cfg(1'b0, 4'h2, 1'b1, 1'b1, 3'h1, 1'b1));
    repeat (70) @(posedge clock);
    gap(1'b1, g);
    check("pwm on divided system", 32'(g), 32'h0000_000C);
    // A second reset in mid-run must bring every field back to its reset value
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd(RMCC_OFF_RCC, 32'h078E_0800);
    rd(RMCC_OFF_STATUS, 32'h0000_0000);
    // Let the last read data be compared before the verdict
    repeat (3) @(posedge clock);
    summarize();
  end
endmodule
`default_nettype wire
